/* rtl/dual_timer_pkg.sv */
// constants for the dual byte timer with capture
package dual_timer_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CONTROL       = 16'hfe10;
  localparam logic [ADDR_W-1:0] OFF_PRESCALE      = 16'hfe11;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LOW     = 16'hfe12;
  localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH    = 16'hfe13;
  localparam logic [ADDR_W-1:0] OFF_MATCH_LOW     = 16'hfe14;
  localparam logic [ADDR_W-1:0] OFF_MATCH_HIGH    = 16'hfe15;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_LOW   = 16'hfe16;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_HIGH  = 16'hfe17;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE2_LOW  = 16'hfe1e;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE2_HIGH = 16'hfe1f;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int BIT_HIGH_RUN   = 7;
  localparam int BIT_LOW_RUN    = 6;
  localparam int BIT_LENGTH     = 5;
  localparam int BIT_LOW_CLOCK  = 4;
  localparam int BIT_HIGH_FLAG  = 3;
  localparam int BIT_HIGH_IE    = 2;
  localparam int BIT_LOW_FLAG   = 1;
  localparam int BIT_LOW_IE     = 0;

  // ----------------------------------------
  // reset and rollover values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] RESET_BYTE   = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_ROLL   = 8'hff;

  typedef enum logic [1:0] {
    mode_split_prescale,
    mode_split_external,
    mode_wide_prescale,
    mode_wide_external
  } mode_t;

endpackage

/* rtl/dual_byte_timer.sv */
// dual byte timer/counter with prescaler, match buffers and capture
//
// Function
// - low run 0: low buffer follows match_low; run 1: reload on low match
// - high run 0: high buffer follows match_high; run 1: reload on high match
// - match when count equals buffer; wide mode needs all sixteen bits equal
// - capture_low takes low count from low input, or high input when wide
// - capture_high takes high count on every high capture strobe
// - capture_second_low takes low count from second low, or second high when wide
// - capture_second_high takes high count on every second high capture strobe
// - four modes from length select and low clock select choose count sources
// - high run 0 holds high counter at zero; 1 lets it count
// - low run 0 holds low counter at zero; 1 lets it count
// - length select 0 gives two 8-bit counters, 1 one 16-bit counter
// - low clock select picks prescaler pulses or external count strobes
// - high flag set on running high match, cleared only by writing 0
// - low flag set on running low match, cleared only by writing 0
// - high flag and high enable raise the high interrupt request
// - low flag and low enable raise the low interrupt request
// - wide mode full match sets both flags in the same cycle when both run bits are set
// - any write to prescaler_match restarts the prescaler at zero
// - prescaler pulses once every prescaler_match plus one cycles
// - wide mode: high counter advances on low counter rollover
// - count registers are read only, reset to zero, read live
// - prescaler counts cycles except in hold, clears on its match
// - each counter returns to zero when stopped and on its match
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps

module dual_byte_timer (
  input  wire logic                              clock,
  input  wire logic                              reset_n,
  input  wire logic [dual_timer_pkg::ADDR_W-1:0] address,
  input  wire logic [dual_timer_pkg::DATA_W-1:0] write_data,
  input  wire logic                              write_strobe,
  input  wire logic                              read_strobe,
  output      logic [dual_timer_pkg::DATA_W-1:0] read_data,
  input  wire logic                              hold_mode,
  input  wire logic                              count_input_a,
  input  wire logic                              count_input_b,
  input  wire logic                              low_capture_input,
  input  wire logic                              high_capture_input,
  input  wire logic                              second_low_capture_input,
  input  wire logic                              second_high_capture_input,
  output      logic                              high_irq,
  output      logic                              low_irq
);
  import dual_timer_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic              high_run;
  logic              low_run;
  logic              length_select;
  logic              low_clock_select;
  logic              high_match_flag;
  logic              high_irq_enable;
  logic              low_match_flag;
  logic              low_irq_enable;
  logic [DATA_W-1:0] prescaler_match;
  logic [DATA_W-1:0] pre_count;
  logic              pre_match;
  logic [DATA_W-1:0] count_low;
  logic [DATA_W-1:0] count_high;
  logic [DATA_W-1:0] match_low;
  logic [DATA_W-1:0] match_high;
  logic [DATA_W-1:0] buf_low;
  logic [DATA_W-1:0] buf_high;
  logic [DATA_W-1:0] capture_low;
  logic [DATA_W-1:0] capture_high;
  logic [DATA_W-1:0] capture_second_low;
  logic [DATA_W-1:0] capture_second_high;

  // ----------------------------------------
  // decode and tick selection
  // ----------------------------------------
  mode_t             mode;
  logic              wr_control;
  logic              wr_prescale;
  logic              ext_tick;
  logic              low_tick;
  logic              high_tick;
  logic              low_equal;
  logic              high_equal;
  logic              full_match;
  logic              low_match;
  logic              high_match;
  logic              low_cap_strobe;
  logic              low2_cap_strobe;
  logic [DATA_W-1:0] control_value;
  logic [DATA_W-1:0] next_read;

  assign wr_control  = write_strobe && (address == OFF_CONTROL);
  assign wr_prescale = write_strobe && (address == OFF_PRESCALE);
  // strobes arrive already aligned to this clock
  assign ext_tick    = count_input_a | count_input_b;
  assign low_equal   = (count_low == buf_low);
  assign high_equal  = (count_high == buf_high);

  always_comb begin
    mode = mode_t'({length_select, low_clock_select});
    low_tick  = 1'b0;
    high_tick = 1'b0;
    unique case (mode)
      mode_split_prescale: begin
        low_tick  = pre_match;
        high_tick = pre_match;
      end
      mode_split_external: begin
        low_tick  = ext_tick;
        high_tick = pre_match;
      end
      mode_wide_prescale: begin
        low_tick  = pre_match;
        high_tick = pre_match && (count_low == COUNT_ROLL);
      end
      mode_wide_external: begin
        low_tick  = ext_tick;
        high_tick = ext_tick && (count_low == COUNT_ROLL);
      end
    endcase
  end

  // wide mode: one match for both halves, so flags move together while both run bits are set
  assign full_match = low_tick && low_equal && high_equal;
  assign low_match  = low_run && (length_select ? full_match
                                                : (low_tick && low_equal));
  assign high_match = high_run && (length_select ? full_match
                                                 : (pre_match && high_equal));

  assign control_value = {high_run, low_run, length_select, low_clock_select,
                          high_match_flag, high_irq_enable, low_match_flag, low_irq_enable};

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      high_run         <= 1'b0;
      low_run          <= 1'b0;
      length_select    <= 1'b0;
      low_clock_select <= 1'b0;
      high_irq_enable  <= 1'b0;
      low_irq_enable   <= 1'b0;
    end else if (wr_control) begin
      high_run         <= write_data[BIT_HIGH_RUN];
      low_run          <= write_data[BIT_LOW_RUN];
      length_select    <= write_data[BIT_LENGTH];
      low_clock_select <= write_data[BIT_LOW_CLOCK];
      high_irq_enable  <= write_data[BIT_HIGH_IE];
      low_irq_enable   <= write_data[BIT_LOW_IE];
    end
  end

  // writing 1 leaves a flag alone; a match in the clearing cycle wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      high_match_flag <= 1'b0;
      low_match_flag  <= 1'b0;
    end else begin
      high_match_flag <= high_match
                       | (high_match_flag & ~(wr_control & ~write_data[BIT_HIGH_FLAG]));
      low_match_flag  <= low_match
                       | (low_match_flag & ~(wr_control & ~write_data[BIT_LOW_FLAG]));
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      high_irq <= 1'b0;
      low_irq  <= 1'b0;
    end else begin
      high_irq <= high_match_flag & high_irq_enable;
      low_irq  <= low_match_flag & low_irq_enable;
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prescaler_match <= RESET_BYTE;
    end else if (wr_prescale) begin
      prescaler_match <= write_data;
    end
  end

  // the pulse is registered, so ticks lag the count equality by one cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre_count <= RESET_BYTE;
      pre_match <= 1'b0;
    end else if (wr_prescale) begin
      pre_count <= RESET_BYTE;
      pre_match <= 1'b0;
    end else if (hold_mode) begin
      pre_match <= 1'b0;
    end else if (pre_count == prescaler_match) begin
      pre_count <= RESET_BYTE;
      pre_match <= 1'b1;
    end else begin
      pre_count <= pre_count + 8'h01;
      pre_match <= 1'b0;
    end
  end

  // ----------------------------------------
  // byte counters
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_low <= RESET_BYTE;
    end else if (!low_run || low_match) begin
      count_low <= RESET_BYTE;
    end else if (low_tick) begin
      count_low <= count_low + 8'h01;
    end
  end

  // wide mode relies on software keeping both run bits equal
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_high <= RESET_BYTE;
    end else if (!high_run || high_match) begin
      count_high <= RESET_BYTE;
    end else if (high_tick) begin
      count_high <= count_high + 8'h01;
    end
  end

  // ----------------------------------------
  // match data and buffers
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      match_low  <= RESET_BYTE;
      match_high <= RESET_BYTE;
    end else if (write_strobe) begin
      if (address == OFF_MATCH_LOW) begin
        match_low <= write_data;
      end
      if (address == OFF_MATCH_HIGH) begin
        match_high <= write_data;
      end
    end
  end

  // a running buffer only reloads at a match, so a new period never tears
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      buf_low <= RESET_BYTE;
    end else if (!low_run || low_match) begin
      buf_low <= match_low;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      buf_high <= RESET_BYTE;
    end else if (!high_run || high_match) begin
      buf_high <= match_high;
    end
  end

  // ----------------------------------------
  // capture registers
  // ----------------------------------------
  assign low_cap_strobe  = length_select ? high_capture_input : low_capture_input;
  assign low2_cap_strobe = length_select ? second_high_capture_input
                                         : second_low_capture_input;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      capture_low         <= RESET_BYTE;
      capture_high        <= RESET_BYTE;
      capture_second_low  <= RESET_BYTE;
      capture_second_high <= RESET_BYTE;
    end else begin
      if (low_cap_strobe) begin
        capture_low <= count_low;
      end
      if (high_capture_input) begin
        capture_high <= count_high;
      end
      if (low2_cap_strobe) begin
        capture_second_low <= count_low;
      end
      if (second_high_capture_input) begin
        capture_second_high <= count_high;
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_comb begin
    next_read = RESET_BYTE;
    if (read_strobe) begin
      unique case (address)
        OFF_CONTROL:       next_read = control_value;
        OFF_PRESCALE:      next_read = prescaler_match;
        OFF_COUNT_LOW:     next_read = count_low;
        OFF_COUNT_HIGH:    next_read = count_high;
        OFF_MATCH_LOW:     next_read = match_low;
        OFF_MATCH_HIGH:    next_read = match_high;
        OFF_CAPTURE_LOW:   next_read = capture_low;
        OFF_CAPTURE_HIGH:  next_read = capture_high;
        OFF_CAPTURE2_LOW:  next_read = capture_second_low;
        OFF_CAPTURE2_HIGH: next_read = capture_second_high;
        default:           next_read = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      read_data <= RESET_BYTE;
    end else begin
      read_data <= next_read;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking chk_cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  chk_prescale_restart: assert property (
    wr_prescale |=> (pre_count == RESET_BYTE) && !pre_match)
    else $error("prescaler not restarted by write");

  chk_prescale_fast: assert property (
    (pre_match && prescaler_match == 8'h00 && !wr_prescale && !hold_mode) |=> pre_match)
    else $error("prescaler of one cycle missed a pulse");

  chk_low_stopped: assert property (
    !low_run |=> (count_low == RESET_BYTE))
    else $error("stopped low counter not zero");

  chk_high_stopped: assert property (
    !high_run |=> (count_high == RESET_BYTE))
    else $error("stopped high counter not zero");

  chk_low_buf_track: assert property (
    !low_run |=> (buf_low == $past(match_low)))
    else $error("idle low buffer not tracking");

  chk_low_buf_hold: assert property (
    (low_run && !low_match) |=> $stable(buf_low))
    else $error("running low buffer changed without a match");

  chk_high_buf_track: assert property (
    !high_run |=> (buf_high == $past(match_high)))
    else $error("idle high buffer not tracking");

  chk_low_flag_set: assert property (
    low_match |=> low_match_flag ##1 (low_irq == low_irq_enable || $past(wr_control)))
    else $error("low flag not set on match");

  chk_high_irq: assert property (
    (high_match_flag && high_irq_enable) |=> high_irq)
    else $error("high interrupt missing");

  chk_low_irq: assert property (
    (low_match_flag && low_irq_enable) |=> low_irq)
    else $error("low interrupt missing");

  chk_wide_flags: assert property (
    (length_select && low_run && high_run && (low_match || high_match)) |=> (low_match_flag && high_match_flag))
    else $error("wide match flags split");

  chk_match_reset: assert property (
    low_match |=> (count_low == RESET_BYTE) && (buf_low == $past(match_low)))
    else $error("low counter not reset on match");

  chk_cap_high: assert property (
    high_capture_input |=> (capture_high == $past(count_high)))
    else $error("high capture wrong");

  chk_count_read: assert property (
    (read_strobe && address == OFF_COUNT_LOW) |=> (read_data == $past(count_low)))
    else $error("live low count not returned");

endmodule

/* testbench/strobe_source.sv */
// far-side model: detection and count strobes from the port edge logic
`timescale 1ns/1ps

module strobe_source (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [5:0] fire,
  output logic            count_input_a,
  output logic            count_input_b,
  output logic            low_capture_input,
  output logic            high_capture_input,
  output logic            second_low_capture_input,
  output logic            second_high_capture_input
);
  // ----------------------------------------
  // registered synchronous strobes that follow fire
  // ----------------------------------------
  // registered so every strobe lasts as many clocks as its fire bit is held and never glitches
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {second_high_capture_input, second_low_capture_input, high_capture_input,
       low_capture_input, count_input_b, count_input_a} <= 6'h00;
    end else begin
      {second_high_capture_input, second_low_capture_input, high_capture_input,
       low_capture_input, count_input_b, count_input_a} <= fire;
    end
  end
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the dual byte timer
`timescale 1ns/1ps

module tb_top;
  import dual_timer_pkg::*;

  typedef struct {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] exp;
  } row_t;

  logic              clock;
  logic              reset_n;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] write_data;
  logic              write_strobe;
  logic              read_strobe;
  logic [DATA_W-1:0] read_data;
  logic              hold_mode;
  logic [5:0]        fire;
  logic              count_input_a;
  logic              count_input_b;
  logic              low_capture_input;
  logic              high_capture_input;
  logic              second_low_capture_input;
  logic              second_high_capture_input;
  logic              high_irq;
  logic              low_irq;
  int                errors;
  int                comparisons;
  logic [DATA_W-1:0] v1;
  logic [DATA_W-1:0] v2;
  row_t              rows [17];

  dual_byte_timer dut (.clock(clock), .reset_n(reset_n), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data), .hold_mode(hold_mode),
    .count_input_a(count_input_a), .count_input_b(count_input_b), .low_capture_input(low_capture_input),
    .high_capture_input(high_capture_input), .second_low_capture_input(second_low_capture_input),
    .second_high_capture_input(second_high_capture_input), .high_irq(high_irq), .low_irq(low_irq));

  strobe_source partner (.clock(clock), .reset_n(reset_n), .fire(fire), .count_input_a(count_input_a),
    .count_input_b(count_input_b), .low_capture_input(low_capture_input),
    .high_capture_input(high_capture_input), .second_low_capture_input(second_low_capture_input),
    .second_high_capture_input(second_high_capture_input));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // two cycles each so a strobe is never lowered and raised in one time step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
    @(posedge clock);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input string name, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    rd(a, d);
    check(name, d, exp);
  endtask

  task automatic pulse(input logic [5:0] m);
    fire <= m;
    @(posedge clock);
    fire <= 6'h00;
    @(posedge clock);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // whole run is under fifteen hundred cycles; this is a generous margin
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    results();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    reset_n = 1'b0;
    address = '0;
    write_data = '0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    hold_mode = 1'b0;
    fire = 6'h00;
    rows = '{'{OFF_CONTROL, 1'b0, 8'h00, 8'h00}, '{OFF_PRESCALE, 1'b0, 8'h00, 8'h00},
             '{OFF_COUNT_LOW, 1'b0, 8'h00, 8'h00}, '{OFF_COUNT_HIGH, 1'b0, 8'h00, 8'h00},
             '{OFF_MATCH_LOW, 1'b0, 8'h00, 8'h00}, '{OFF_MATCH_HIGH, 1'b0, 8'h00, 8'h00},
             '{OFF_CAPTURE_LOW, 1'b0, 8'h00, 8'h00}, '{OFF_CAPTURE_HIGH, 1'b0, 8'h00, 8'h00},
             '{OFF_CAPTURE2_LOW, 1'b0, 8'h00, 8'h00}, '{OFF_CAPTURE2_HIGH, 1'b0, 8'h00, 8'h00},
             '{16'hfe18, 1'b0, 8'h00, 8'h00}, '{OFF_PRESCALE, 1'b1, 8'h33, 8'h33},
             '{OFF_MATCH_LOW, 1'b1, 8'h5a, 8'h5a}, '{OFF_MATCH_HIGH, 1'b1, 8'ha5, 8'ha5},
             '{OFF_COUNT_LOW, 1'b1, 8'h77, 8'h00}, '{OFF_CAPTURE_HIGH, 1'b1, 8'h77, 8'h00},
             '{16'hfe18, 1'b1, 8'h77, 8'h00}};
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data);
      end
      rdc(rows[i].addr, "register table", rows[i].exp);
    end
    #1 check("read_data idle", read_data, 8'h00);
    @(posedge clock);
    done("register table");

    // prescaler period five: fifty cycles give ten ticks
    wr(OFF_PRESCALE, 8'h04);
    wr(OFF_MATCH_LOW, 8'hff);
    wr(OFF_CONTROL, 8'h40);
    rd(OFF_COUNT_LOW, v1);
    repeat (48) @(posedge clock);
    rd(OFF_COUNT_LOW, v2);
    check("ticks in 50 cycles", v2 - v1, 8'h0a);
    hold_mode <= 1'b1;
    repeat (3) @(posedge clock);
    rd(OFF_COUNT_LOW, v1);
    repeat (48) @(posedge clock);
    rd(OFF_COUNT_LOW, v2);
    check("ticks in hold", v2 - v1, 8'h00);
    hold_mode <= 1'b0;
    wr(OFF_CONTROL, 8'h00);
    rdc(OFF_COUNT_LOW, "stopped low count", 8'h00);
    done("prescaler");

    // low match while stopped buffer follows the match register
    wr(OFF_PRESCALE, 8'h00);
    wr(OFF_MATCH_LOW, 8'h02);
    wr(OFF_CONTROL, 8'h41);
    repeat (10) @(posedge clock);
    rdc(OFF_CONTROL, "low flag set", 8'h43);
    check("low irq", {7'h00, low_irq}, 8'h01);
    rd(OFF_COUNT_LOW, v1);
    check("low count bound", {7'h00, v1 <= 8'h02}, 8'h01);
    wr(OFF_CONTROL, 8'h01);
    rdc(OFF_CONTROL, "low flag cleared", 8'h01);
    check("low irq cleared", {7'h00, low_irq}, 8'h00);
    done("low match");

    wr(OFF_MATCH_HIGH, 8'h03);
    wr(OFF_CONTROL, 8'h84);
    repeat (10) @(posedge clock);
    rdc(OFF_CONTROL, "high flag set", 8'h8c);
    check("high irq", {7'h00, high_irq}, 8'h01);
    check("low irq quiet", {7'h00, low_irq}, 8'h00);
    wr(OFF_CONTROL, 8'h88);
    rdc(OFF_CONTROL, "flag kept by one", 8'h88);
    check("high irq masked", {7'h00, high_irq}, 8'h00);
    wr(OFF_CONTROL, 8'h00);
    rdc(OFF_CONTROL, "high flag cleared", 8'h00);
    rdc(OFF_COUNT_HIGH, "stopped high count", 8'h00);
    done("high match");

    // wide prescaled mode, match at 0x0200; low byte alone passes 00 early
    wr(OFF_MATCH_LOW, 8'h00);
    wr(OFF_MATCH_HIGH, 8'h02);
    wr(OFF_CONTROL, 8'he0);
    repeat (290) @(posedge clock);
    rdc(OFF_COUNT_HIGH, "carry into high", 8'h01);
    rdc(OFF_CONTROL, "no partial match", 8'he0);
    repeat (250) @(posedge clock);
    rdc(OFF_CONTROL, "both flags together", 8'hea);
    wr(OFF_CONTROL, 8'h00);
    done("wide prescaled");

    // external counting and captures; slow prescaler must not add counts
    wr(OFF_PRESCALE, 8'hff);
    wr(OFF_MATCH_LOW, 8'hff);
    wr(OFF_MATCH_HIGH, 8'hff);
    wr(OFF_CONTROL, 8'h50);
    repeat (3) pulse(6'h01);
    repeat (2) pulse(6'h02);
    rdc(OFF_COUNT_LOW, "external count", 8'h05);
    pulse(6'h04);
    pulse(6'h10);
    pulse(6'h01);
    pulse(6'h08);
    rdc(OFF_CAPTURE_LOW, "split capture low", 8'h05);
    rdc(OFF_CAPTURE2_LOW, "split capture2 low", 8'h05);
    rdc(OFF_CAPTURE_HIGH, "split capture high", 8'h00);
    wr(OFF_CONTROL, 8'hf0);
    repeat (256) pulse(6'h01);
    pulse(6'h08);
    pulse(6'h20);
    rdc(OFF_COUNT_HIGH, "wide external high", 8'h01);
    rdc(OFF_CAPTURE_LOW, "wide capture low", 8'h06);
    rdc(OFF_CAPTURE_HIGH, "wide capture high", 8'h01);
    rdc(OFF_CAPTURE2_LOW, "wide capture2 low", 8'h06);
    rdc(OFF_CAPTURE2_HIGH, "wide capture2 high", 8'h01);
    done("external and capture");

    // a running buffer keeps its old value until the next match
    wr(OFF_CONTROL, 8'h00);
    wr(OFF_MATCH_LOW, 8'h02);
    wr(OFF_CONTROL, 8'h50);
    wr(OFF_MATCH_LOW, 8'h04);
    repeat (3) pulse(6'h01);
    rdc(OFF_COUNT_LOW, "match on old buffer", 8'h00);
    rdc(OFF_CONTROL, "flag on buffered match", 8'h52);
    repeat (4) pulse(6'h01);
    rdc(OFF_COUNT_LOW, "count up to new buffer", 8'h04);
    pulse(6'h01);
    rdc(OFF_COUNT_LOW, "match on new buffer", 8'h00);
    done("buffer reload");

    // reset in mid-run
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rdc(OFF_CONTROL, "control after reset", 8'h00);
    rdc(OFF_COUNT_HIGH, "count after reset", 8'h00);
    done("second reset");
    results();
  end
endmodule
